//--- shared/bbie_pkg.sv
package bbie_pkg;
    // core timing: four sub-phases per instruction cycle at 40 MHz
    localparam int MCLK_HZ = 40_000_000;
    localparam int Q_PER_CYC = 4;
    localparam int NOP_CNT_W = 4;
    // file memory layout
    localparam int FILE_AW = 12;
    localparam int BANK_W = 4;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    // register offsets on the avalon slave (byte addresses)
    localparam int AV_AW = 6;
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_ACC = 6'h04;
    localparam logic [5:0] REG_BANK = 6'h08;
    localparam logic [5:0] REG_STATUS = 6'h0c;
    localparam logic [5:0] REG_INSTR = 6'h10;
    localparam logic [5:0] REG_EXEC = 6'h14;
    localparam logic [5:0] REG_IDX_BASE = 6'h18;
    localparam logic [5:0] REG_MEM_ADDR = 6'h1c;
    localparam logic [5:0] REG_MEM_DATA = 6'h20;
    localparam logic [5:0] REG_PC = 6'h24;
    // field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int INSTR_TWO_WORD_BIT = 16;
    localparam int EX_BUSY_BIT = 0;
    localparam int EX_SKIP_BIT = 1;
    localparam int EX_UNSUP_BIT = 2;
    localparam int EX_CYC_LSB = 8;
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_N = 4;
    localparam int OP_D_BIT = 9;
    localparam int OP_A_BIT = 8;
    // opcode patterns
    localparam logic [5:0] PAT_ADC = 6'h08;
    localparam logic [7:0] PAT_ANDL = 8'h0b;
    localparam logic [3:0] PAT_BTC = 4'hb;
    localparam logic [3:0] PAT_BTS = 4'ha;
    localparam logic [6:0] PAT_CGT = 7'h32;
    localparam logic [6:0] PAT_CLT = 7'h30;
    // cycle figures
    localparam logic [1:0] CYC_PLAIN = 2'h1;
    localparam logic [1:0] CYC_SKIP1 = 2'h2;
    localparam logic [1:0] CYC_SKIP2 = 2'h3;
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_Q1 = 4'b0001,
        ST_Q2 = 4'b0010,
        ST_Q3 = 4'b0011,
        ST_Q4 = 4'b0100,
        ST_NOP = 4'b0101,
        ST_MRD = 4'b0110,
        ST_MRD2 = 4'b0111
    } bbie_state_t;

    typedef enum logic [2:0] {
        OP_ADC = 3'b000,
        OP_ANDL = 3'b001,
        OP_BTC = 3'b010,
        OP_BTS = 3'b011,
        OP_CGT = 3'b100,
        OP_CLT = 3'b101,
        OP_OTHER = 3'b110
    } bbie_op_t;
endpackage

//--- shared/bbie_mem_if.sv
`timescale 1ns/1ps
// file memory port between the execution core and the storage
interface bbie_mem_if #(parameter int AW = bbie_pkg::FILE_AW);
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic we;
    modport core (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface

//--- verilog/bbie_file_mem.sv
`timescale 1ns/1ps
// byte-wide data file, registered read data, write-first not needed
module bbie_file_mem #(
    parameter int AW = bbie_pkg::FILE_AW
) (
    input wire logic mclk, // core clock
    bbie_mem_if.mem mif // storage side of the memory port
);
    logic [7:0] store [0:(1<<AW)-1];
    logic [7:0] rdata_q;

    // one write and one registered read per clock
    always_ff @(posedge mclk)
    begin
        if (mif.we)
        begin
            store[mif.addr] <= mif.wdata;
        end
        rdata_q <= store[mif.addr];
    end

    assign mif.rdata = rdata_q;
endmodule

//--- verilog/bbie_core.sv
`timescale 1ns/1ps
// Contract
// - add-with-carry sums accumulator, file register and carry into the destination
// - destination bit 0 writes the accumulator, 1 writes the file register
// - bank bit 0 uses access bank, 1 uses the bank selector
// - extended set with bank bit 0 indexes addresses up to 95 off a base
// - and-literal ands the accumulator with the opcode literal into the accumulator
// - bit test skips the next instruction when the selected bit is 0
// - bit test skips the next instruction when the selected bit is 1
// - compare skips when the file register exceeds the accumulator
// - compare skips when the file register is below the accumulator
// - compares are unsigned, by subtracting accumulator from file register
// - a taken skip replaces each word of the next instruction by one idle cycle
// - skipping a two-word instruction costs three cycles in total
module bbie_core (
    input wire logic mclk, // core clock, 40 MHz
    input wire logic rst, // asynchronous reset, active high
    input wire logic [bbie_pkg::AV_AW-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // lane 0 must be set for writes
    output logic [31:0] avs_readdata, // read data, registered
    output logic avs_waitrequest // high until the request is answered
);
    typedef struct packed {
        bbie_pkg::bbie_state_t state;
        logic waitrequest;
        logic [31:0] readdata;
        logic ext_en;
        logic [7:0] acc;
        logic [bbie_pkg::BANK_W-1:0] bank;
        logic [7:0] status;
        logic [bbie_pkg::FILE_AW-1:0] idx_base;
        logic [bbie_pkg::FILE_AW-1:0] mem_addr_sw;
        logic [15:0] pc;
        logic [15:0] opcode;
        logic two_word;
        logic [bbie_pkg::FILE_AW-1:0] mem_addr;
        logic [7:0] mem_wdata;
        logic mem_we;
        logic skip;
        logic unsup;
        logic [1:0] last_cycles;
        logic [bbie_pkg::NOP_CNT_W-1:0] nop_cnt;
        logic [bbie_pkg::NOP_CNT_W-1:0] nop_run;
    } bbie_regs_t;

    bbie_regs_t st;
    bbie_regs_t next_st;
    bbie_mem_if #(.AW(bbie_pkg::FILE_AW)) mif ();
    bbie_pkg::bbie_op_t cls;
    logic bus_req;
    logic [7:0] fval;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [8:0] diff9;
    logic [7:0] res;

    // instruction class from the opcode
    function automatic bbie_pkg::bbie_op_t classify(input logic [15:0] op);
        if (op[15:10] == bbie_pkg::PAT_ADC) return bbie_pkg::OP_ADC;
        else if (op[15:8] == bbie_pkg::PAT_ANDL) return bbie_pkg::OP_ANDL;
        else if (op[15:12] == bbie_pkg::PAT_BTC) return bbie_pkg::OP_BTC;
        else if (op[15:12] == bbie_pkg::PAT_BTS) return bbie_pkg::OP_BTS;
        else if (op[15:9] == bbie_pkg::PAT_CGT) return bbie_pkg::OP_CGT;
        else if (op[15:9] == bbie_pkg::PAT_CLT) return bbie_pkg::OP_CLT;
        else return bbie_pkg::OP_OTHER;
    endfunction

    // effective file address: banked, indexed or access bank
    function automatic logic [bbie_pkg::FILE_AW-1:0] file_addr(
        input logic [15:0] op,
        input logic ext,
        input logic [bbie_pkg::BANK_W-1:0] bank,
        input logic [bbie_pkg::FILE_AW-1:0] base
    );
        logic [7:0] f;
        f = op[7:0];
        if (op[bbie_pkg::OP_A_BIT]) return {bank, f};
        else if (ext && f <= bbie_pkg::INDEXED_MAX) return base + {4'h0, f};
        else if (f < bbie_pkg::ACCESS_SPLIT) return {bbie_pkg::ACCESS_LO_BANK, f};
        else return {bbie_pkg::ACCESS_HI_BANK, f};
    endfunction

    // register read mux; unmapped offsets read as zero
    function automatic logic [31:0] reg_read(input logic [bbie_pkg::AV_AW-1:0] a,
                                             input bbie_regs_t s);
        logic [31:0] v;
        v = '0;
        unique case (a)
            bbie_pkg::REG_CTRL: v[bbie_pkg::CTRL_EXT_BIT] = s.ext_en;
            bbie_pkg::REG_ACC: v[7:0] = s.acc;
            bbie_pkg::REG_BANK: v[bbie_pkg::BANK_W-1:0] = s.bank;
            bbie_pkg::REG_STATUS: v[7:0] = s.status;
            bbie_pkg::REG_INSTR: v[16:0] = {s.two_word, s.opcode};
            bbie_pkg::REG_EXEC:
            begin
                v[bbie_pkg::EX_SKIP_BIT] = s.skip;
                v[bbie_pkg::EX_UNSUP_BIT] = s.unsup;
                v[bbie_pkg::EX_CYC_LSB+:2] = s.last_cycles;
            end
            bbie_pkg::REG_IDX_BASE: v[bbie_pkg::FILE_AW-1:0] = s.idx_base;
            bbie_pkg::REG_MEM_ADDR: v[bbie_pkg::FILE_AW-1:0] = s.mem_addr_sw;
            bbie_pkg::REG_PC: v[15:0] = s.pc;
            default: v = '0;
        endcase
        return v;
    endfunction

    assign cls = classify(st.opcode);

    // next-state logic: bus slave, execution phases, skip cycles
    always_comb
    begin
        next_st = st;
        next_st.mem_we = 1'b0;
        next_st.waitrequest = 1'b1;
        // helper: length of an idle run, for the skip checks
        next_st.nop_run = (st.state == bbie_pkg::ST_NOP) ? st.nop_run + 1'b1 : '0;
        bus_req = (avs_read || avs_write) && st.waitrequest;
        fval = mif.rdata;
        sum9 = {1'b0, st.acc} + {1'b0, fval} + {8'h00, st.status[bbie_pkg::FLG_C]};
        nib5 = {1'b0, st.acc[3:0]} + {1'b0, fval[3:0]} + {4'h0, st.status[bbie_pkg::FLG_C]};
        diff9 = {1'b0, fval} - {1'b0, st.acc};
        res = sum9[7:0];
        unique case (st.state)
            bbie_pkg::ST_IDLE:
            begin
                if (bus_req && avs_read && avs_address == bbie_pkg::REG_MEM_DATA)
                begin
                    next_st.mem_addr = st.mem_addr_sw;
                    next_st.state = bbie_pkg::ST_MRD;
                end
                else if (bus_req)
                begin
                    next_st.waitrequest = 1'b0;
                    next_st.readdata = reg_read(avs_address, st);
                end
                else if (avs_write && !st.waitrequest && avs_byteenable[0])
                begin
                    // write takes effect at the edge where it is answered
                    unique case (avs_address)
                        bbie_pkg::REG_CTRL: next_st.ext_en = avs_writedata[bbie_pkg::CTRL_EXT_BIT];
                        bbie_pkg::REG_ACC: next_st.acc = avs_writedata[7:0];
                        bbie_pkg::REG_BANK: next_st.bank = avs_writedata[bbie_pkg::BANK_W-1:0];
                        bbie_pkg::REG_STATUS: next_st.status = avs_writedata[7:0];
                        bbie_pkg::REG_INSTR:
                        begin
                            next_st.opcode = avs_writedata[15:0];
                            next_st.two_word = avs_writedata[bbie_pkg::INSTR_TWO_WORD_BIT];
                            next_st.state = bbie_pkg::ST_Q1;
                        end
                        bbie_pkg::REG_IDX_BASE:
                            next_st.idx_base = avs_writedata[bbie_pkg::FILE_AW-1:0];
                        bbie_pkg::REG_MEM_ADDR:
                            next_st.mem_addr_sw = avs_writedata[bbie_pkg::FILE_AW-1:0];
                        bbie_pkg::REG_MEM_DATA:
                        begin
                            next_st.mem_addr = st.mem_addr_sw;
                            next_st.mem_wdata = avs_writedata[7:0];
                            next_st.mem_we = 1'b1;
                        end
                        bbie_pkg::REG_PC: next_st.pc = avs_writedata[15:0];
                        default: next_st.pc = st.pc; // unmapped: ignored
                    endcase
                end
            end
            bbie_pkg::ST_MRD: next_st.state = bbie_pkg::ST_MRD2;
            bbie_pkg::ST_MRD2:
            begin
                next_st.readdata = {24'h000000, mif.rdata};
                next_st.waitrequest = 1'b0;
                next_st.state = bbie_pkg::ST_IDLE;
            end
            bbie_pkg::ST_Q1:
            begin
                // decode: present the operand address
                next_st.mem_addr = file_addr(st.opcode, st.ext_en, st.bank, st.idx_base);
                next_st.state = bbie_pkg::ST_Q2;
            end
            bbie_pkg::ST_Q2: next_st.state = bbie_pkg::ST_Q3;
            bbie_pkg::ST_Q3:
            begin
                // process data and decide the skip
                next_st.skip = 1'b0;
                next_st.unsup = 1'b0;
                unique case (cls)
                    bbie_pkg::OP_ADC:
                    begin
                        next_st.status[bbie_pkg::FLG_C] = sum9[8];
                        next_st.status[bbie_pkg::FLG_DC] = nib5[4];
                        next_st.status[bbie_pkg::FLG_Z] = (res == 8'h00);
                        next_st.status[bbie_pkg::FLG_N] = res[7];
                        next_st.status[bbie_pkg::FLG_OV] = (st.acc[7] == fval[7]) && (res[7] != st.acc[7]);
                        if (st.opcode[bbie_pkg::OP_D_BIT])
                        begin
                            next_st.mem_wdata = res;
                            next_st.mem_we = 1'b1;
                        end
                        else
                        begin
                            next_st.acc = res;
                        end
                    end
                    bbie_pkg::OP_ANDL:
                    begin
                        next_st.acc = st.acc & st.opcode[7:0];
                        next_st.status[bbie_pkg::FLG_Z] = ((st.acc & st.opcode[7:0]) == 8'h00);
                        next_st.status[bbie_pkg::FLG_N] = st.acc[7] & st.opcode[7];
                    end
                    bbie_pkg::OP_BTC: next_st.skip = !fval[st.opcode[11:9]];
                    bbie_pkg::OP_BTS: next_st.skip = fval[st.opcode[11:9]];
                    bbie_pkg::OP_CGT: next_st.skip = !diff9[8] && (diff9[7:0] != 8'h00);
                    bbie_pkg::OP_CLT: next_st.skip = diff9[8];
                    default: next_st.unsup = 1'b1;
                endcase
                next_st.state = bbie_pkg::ST_Q4;
            end
            bbie_pkg::ST_Q4:
            begin
                // count cycles and advance the program counter
                if (st.skip && st.two_word)
                begin
                    next_st.last_cycles = bbie_pkg::CYC_SKIP2;
                    next_st.nop_cnt = bbie_pkg::NOP_CNT_W'(2 * bbie_pkg::Q_PER_CYC - 1);
                    next_st.pc = st.pc + 16'(bbie_pkg::CYC_SKIP2);
                    next_st.state = bbie_pkg::ST_NOP;
                end
                else if (st.skip)
                begin
                    next_st.last_cycles = bbie_pkg::CYC_SKIP1;
                    next_st.nop_cnt = bbie_pkg::NOP_CNT_W'(bbie_pkg::Q_PER_CYC - 1);
                    next_st.pc = st.pc + 16'(bbie_pkg::CYC_SKIP1);
                    next_st.state = bbie_pkg::ST_NOP;
                end
                else
                begin
                    next_st.last_cycles = bbie_pkg::CYC_PLAIN;
                    next_st.pc = st.pc + 16'(bbie_pkg::CYC_PLAIN);
                    next_st.state = bbie_pkg::ST_IDLE;
                end
            end
            bbie_pkg::ST_NOP:
            begin
                // discarded words run as idle cycles
                if (st.nop_cnt == '0) next_st.state = bbie_pkg::ST_IDLE;
                else next_st.nop_cnt = st.nop_cnt - 1'b1;
            end
            default: next_st.state = bbie_pkg::ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.state <= bbie_pkg::ST_IDLE;
            st.waitrequest <= 1'b1;
            st.status <= bbie_pkg::STATUS_RST;
            st.pc <= bbie_pkg::PC_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // memory port and bus outputs straight from flops
    assign mif.addr = st.mem_addr;
    assign mif.wdata = st.mem_wdata;
    assign mif.we = st.mem_we;
    assign avs_readdata = st.readdata;
    assign avs_waitrequest = st.waitrequest;

    bbie_file_mem #(.AW(bbie_pkg::FILE_AW)) u_mem (
        .mclk(mclk),
        .mif(mif)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_adc_to_acc: assert property (
        st.state == bbie_pkg::ST_Q3 && cls == bbie_pkg::OP_ADC && !st.opcode[bbie_pkg::OP_D_BIT]
        |=> st.acc == 8'($past(st.acc) + $past(mif.rdata) + {7'h00, $past(st.status[0])}))
        else $error("add with carry gave a wrong accumulator");
    a_adc_to_file: assert property (
        st.state == bbie_pkg::ST_Q3 && cls == bbie_pkg::OP_ADC && st.opcode[bbie_pkg::OP_D_BIT]
        |=> mif.we && $stable(st.acc) && mif.addr == $past(mif.addr))
        else $error("add with carry to file did not write the file");
    a_adc_file_data: assert property (
        st.state == bbie_pkg::ST_Q3 && cls == bbie_pkg::OP_ADC && st.opcode[bbie_pkg::OP_D_BIT]
        |=> mif.wdata == 8'($past(st.acc) + $past(mif.rdata) + {7'h00, $past(st.status[0])}))
        else $error("add with carry wrote wrong file data");
    a_bank_addr: assert property (
        st.state == bbie_pkg::ST_Q1 && st.opcode[bbie_pkg::OP_A_BIT]
        |=> mif.addr == {$past(st.bank), $past(st.opcode[7:0])})
        else $error("banked address wrong");
    a_indexed_addr: assert property (
        st.state == bbie_pkg::ST_Q1 && !st.opcode[bbie_pkg::OP_A_BIT] && st.ext_en
        && st.opcode[7:0] <= bbie_pkg::INDEXED_MAX
        |=> mif.addr == $past(st.idx_base) + {4'h0, $past(st.opcode[7:0])})
        else $error("indexed address wrong");
    a_and_literal: assert property (
        st.state == bbie_pkg::ST_Q3 && cls == bbie_pkg::OP_ANDL
        |=> st.acc == ($past(st.acc) & $past(st.opcode[7:0])) && !mif.we)
        else $error("and literal gave a wrong accumulator");
    a_btc_skip: assert property (
        st.state == bbie_pkg::ST_Q3 && cls == bbie_pkg::OP_BTC
        |=> st.skip == !$past(mif.rdata[st.opcode[11:9]]))
        else $error("clear bit test skip decision wrong");
    a_bts_skip: assert property (
        st.state == bbie_pkg::ST_Q3 && cls == bbie_pkg::OP_BTS
        |=> st.skip == $past(mif.rdata[st.opcode[11:9]]))
        else $error("set bit test skip decision wrong");
    a_cmp_greater: assert property (
        st.state == bbie_pkg::ST_Q3 && cls == bbie_pkg::OP_CGT
        |=> st.skip == ($past(mif.rdata) > $past(st.acc)))
        else $error("greater compare skip wrong");
    a_cmp_less: assert property (
        st.state == bbie_pkg::ST_Q3 && cls == bbie_pkg::OP_CLT
        |=> st.skip == ($past(mif.rdata) < $past(st.acc)))
        else $error("less compare skip wrong");
    a_skip_one_word: assert property (
        st.state == bbie_pkg::ST_Q4 && st.skip && !st.two_word
        |=> (st.state == bbie_pkg::ST_NOP) [*4] ##1 st.state == bbie_pkg::ST_IDLE)
        else $error("single skip did not idle one cycle");
    a_skip_two_word: assert property (
        st.state == bbie_pkg::ST_NOP && next_st.state == bbie_pkg::ST_IDLE && st.two_word
        |-> st.nop_run == 4'h7 && st.last_cycles == bbie_pkg::CYC_SKIP2)
        else $error("two-word skip did not take three cycles");
    a_and_flags: assert property (
        st.state == bbie_pkg::ST_Q3 && cls == bbie_pkg::OP_ANDL
        |=> st.status[1:0] == $past(st.status[1:0]) && st.status[3] == $past(st.status[3]))
        else $error("and literal touched carry, digit carry or overflow");
    a_test_no_side: assert property (
        st.state == bbie_pkg::ST_Q3 && cls inside {bbie_pkg::OP_BTC, bbie_pkg::OP_BTS,
        bbie_pkg::OP_CGT, bbie_pkg::OP_CLT}
        |=> $stable(st.status) && $stable(st.acc) && !mif.we)
        else $error("test instruction changed data or flags");

    c_adc_file: cover property (st.state == bbie_pkg::ST_Q4 && cls == bbie_pkg::OP_ADC && mif.we);
    c_skip_two: cover property (st.state == bbie_pkg::ST_NOP && st.two_word && st.nop_run == 4'h7);
    c_less_skip: cover property (st.state == bbie_pkg::ST_Q4 && cls == bbie_pkg::OP_CLT && st.skip);
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] q;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    // 40 MHz core clock
    always #12.5 mclk = ~mclk;
    bbie_core u_dut (
        .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );
    // verdict and end of run
    task automatic final_report();
        $display("errors %0d, checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            error_cnt++;
            final_report();
        end
    end
    // register word compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            error_cnt++;
    endtask
    // cycles an instruction takes: one, plus the words it skips
    function automatic logic [1:0] exp_cyc(input logic sk, input logic tw);
        return sk ? (tw ? 2'h3 : 2'h2) : 2'h1;
    endfunction
    // one bus transfer, held until waitrequest is seen low
    task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        // answer taken at the rising edge where waitrequest is seen low
        do
            @(posedge mclk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    initial
    begin
        int i;
        logic [7:0] acc, fv, f, st, ae, me, se;
        logic [8:0] sum;
        logic [2:0] b;
        logic d, a, tw, ext, sk;
        logic [3:0] bk;
        logic [11:0] base, fa;
        logic [15:0] op, pc_e;
        void'($urandom(7));
        pc_e = 16'h0000;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        // reset values and an unmapped offset
        av(1'b0, bbie_pkg::REG_STATUS, 32'h0);
        chk(q, 32'h0000_0000);
        av(1'b0, 6'h3c, 32'h0);
        chk(q, 32'h0000_0000);
        // a write without lane 0 is answered but ignored
        avs_byteenable <= 4'he;
        av(1'b1, bbie_pkg::REG_ACC, 32'h0000_00ff);
        avs_byteenable <= 4'hf;
        av(1'b0, bbie_pkg::REG_ACC, 32'h0);
        chk(q, 32'h0000_0000);
        for (i = 0; i < 96; i++)
        begin
            acc = 8'($urandom);
            fv = (i % 12 < 2 || i % 12 > 9) ? acc : 8'($urandom);
            st = 8'($urandom % 32);
            b = 3'($urandom);
            d = 1'($urandom);
            tw = 1'($urandom);
            bk = 4'($urandom);
            base = 12'($urandom);
            f = 8'($urandom);
            a = (i % 4 == 2);
            ext = (i % 4 == 3);
            if (i % 4 == 0 || i % 4 == 3)
                f = (i % 8 == 3) ? 8'h5f : 8'($urandom % 96);
            if (i % 4 == 1)
                f = 8'h60 + 8'($urandom % 160);
            fa = a ? {bk, f} : (ext ? base + {4'h0, f} : {(f < 8'h60) ? 4'h0 : 4'hf, f});
            // expected outcome worked out from the operands
            ae = acc;
            me = fv;
            se = st;
            sk = 1'b0;
            case (i % 6)
                0: op = {6'b001000, d, a, f};
                1: op = {8'h0b, fv};
                2: op = {4'hb, b, a, f};
                3: op = {4'ha, b, a, f};
                4: op = {7'b0110010, a, f};
                default: op = {7'b0110000, a, f};
            endcase
            sum = {1'b0, acc} + {1'b0, fv} + {8'h00, st[0]};
            if (i % 6 == 0)
            begin
                se = {3'h0, sum[7], (acc[7] == fv[7]) && (sum[7] != acc[7]), sum[7:0] == 8'h00,
                    ({1'b0, acc[3:0]} + {1'b0, fv[3:0]} + {4'h0, st[0]}) > 5'h0f, sum[8]};
                if (d)
                    me = sum[7:0];
                else
                    ae = sum[7:0];
            end
            if (i % 6 == 1)
            begin
                ae = acc & fv;
                se = {3'h0, ae[7], st[3], ae == 8'h00, st[1:0]};
            end
            sk = (i % 6 == 2) ? !fv[b] : (i % 6 == 3) ? fv[b] : sk;
            sk = (i % 6 == 4) ? fv > acc : (i % 6 == 5) ? fv < acc : sk;
            pc_e = pc_e + {14'h0, exp_cyc(sk, tw)};
            av(1'b1, bbie_pkg::REG_CTRL, {31'h0, ext});
            av(1'b1, bbie_pkg::REG_BANK, {28'h0, bk});
            av(1'b1, bbie_pkg::REG_IDX_BASE, {20'h0, base});
            av(1'b1, bbie_pkg::REG_MEM_ADDR, {20'h0, fa});
            av(1'b1, bbie_pkg::REG_MEM_DATA, {24'h0, fv});
            av(1'b1, bbie_pkg::REG_ACC, {24'h0, acc});
            av(1'b1, bbie_pkg::REG_STATUS, {24'h0, st});
            av(1'b1, bbie_pkg::REG_INSTR, {15'h0, tw, op});
            av(1'b0, bbie_pkg::REG_ACC, 32'h0);
            chk(q, {24'h0, ae});
            av(1'b0, bbie_pkg::REG_MEM_DATA, 32'h0);
            chk(q, {24'h0, me});
            av(1'b0, bbie_pkg::REG_STATUS, 32'h0);
            chk(q, {24'h0, se});
            av(1'b0, bbie_pkg::REG_EXEC, 32'h0);
            chk({q[9:8], q[2:1]}, {exp_cyc(sk, tw), 1'b0, sk});
            av(1'b0, bbie_pkg::REG_PC, 32'h0);
            chk(q, {16'h0, pc_e});
        end
        // an opcode outside the group: one cycle, flagged, no skip
        av(1'b1, bbie_pkg::REG_INSTR, 32'h0000_0000);
        av(1'b0, bbie_pkg::REG_EXEC, 32'h0);
        chk({q[9:8], q[2:1]}, {exp_cyc(1'b0, 1'b0), 1'b1, 1'b0});
        pc_e = pc_e + 16'h0001;
        av(1'b0, bbie_pkg::REG_PC, 32'h0);
        chk(q, {16'h0, pc_e});
        // reset again in mid-run: registers return to zero
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        av(1'b0, bbie_pkg::REG_PC, 32'h0);
        chk(q, 32'h0000_0000);
        av(1'b0, bbie_pkg::REG_STATUS, 32'h0);
        chk(q, 32'h0000_0000);
        final_report();
    end
endmodule
